/* File: rtl/cvac_map.svh */
// register map, field positions, reset values and timing counts for the acquisition control
// What this block does
// R1: converter offers four resolutions: 11, 13, 15 and 16 bits.
// R2: converter powers down on its own at the end of every conversion.
// R3: all configuration and result access goes through the peripheral port.
// R4: cell count 00 off, 01 two cells, 10 three, 11 four cells.
// R5: nonzero cell count enables bias cancel, only while converting.
// R6: range mode 00 low/ground, 01 high/pack, 10 high/ground, 11 differential.
// R7: low-voltage channels: ground, temperature, supply, reference, pack negative, aux.
// R8: high-voltage versus pack negative: codes 0-3 pick cell tops 1-4.
// R9: high-voltage versus ground: codes 0-3 pick cell tops 1-4.
// R10: differential: cell1 minus pack, then each cell top minus the one below.
// R11: software sets cell count, then mode and channel, then starts.
// R12: writing one to the go bit powers up and starts a conversion.
// R13: go bit clears itself when the conversion completes.
// R14: result readable as high and low bytes after completion.
// R15: with irq enable set, interrupts at start and end; none when clear.
// R16: each converter gives up pulses for rising and down pulses for falling LSBs.
// R17: conversions run on their own without the CPU.
// R18: resolution field 00,01,10,11 means 11,13,15,16 bits.
// R19: go bit is D0 of the converter control register.
// R20: irq enable is D3 of the converter control register.
// R21: result low byte at 0x12, high byte at 0x13.
// R22: a go write during a running conversion is ignored.
// R23: begin and end interrupts are one-cycle pulses synchronised from the timebase.
`ifndef CVAC_MAP_SVH
`define CVAC_MAP_SVH
`define CVAC_ADDR_FE_CFG 8'h10
`define CVAC_ADDR_CONV_CTL 8'h11
`define CVAC_ADDR_RES_LO 8'h12
`define CVAC_ADDR_RES_HI 8'h13
`define CVAC_FE_CFG_RST 8'h00
`define CVAC_CONV_CTL_RST 8'h32
`define CVAC_GO_BIT 0
`define CVAC_RES_LSB 1
`define CVAC_IRQ_EN_BIT 3
`define CVAC_CHOP_BIT 4
`define CVAC_LIMIT_BIT 5
`define CVAC_SEL_LSB 0
`define CVAC_MODE_LSB 3
`define CVAC_CELL_LSB 5
`define CVAC_WAKE_TICKS 4'h2
`endif

/* File: rtl/cvac_pkg.sv */
// types shared by the acquisition control files
package cvac_pkg;
  typedef enum logic [1:0] {CVAC_BIAS_OFF, CVAC_TWO_CELL, CVAC_THREE_CELL, CVAC_FOUR_CELL} cvac_cell_e;
  typedef enum logic [1:0] {CVAC_LV_GND, CVAC_HV_PACK, CVAC_HV_GND, CVAC_HV_DIFF} cvac_mode_e;
  // analog node selections driven to the front end mux
  typedef enum logic [3:0]
  {
    CVAC_N_GND, CVAC_N_TEMP, CVAC_N_SUPPLY, CVAC_N_REF, CVAC_N_PACK, CVAC_N_AUX,
    CVAC_N_C1, CVAC_N_C2, CVAC_N_C3, CVAC_N_C4, CVAC_N_NONE
  } cvac_node_e;
  typedef logic [17:0] cvac_count_t;
endpackage

/* File: rtl/cvac_pulse_sync.sv */
// carries a timebase event into the cpu clock as a single-cycle pulse
module cvac_pulse_sync
(
  input wire logic core_clk, // cpu clock
  input wire logic rst, // synchronous reset
  input wire logic level_in, // toggling level from the timebase side
  output logic pulse_out // one-cycle pulse per toggle
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= level_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign pulse_out = s2_q ^ s3_q; // [R23]
endmodule

/* File: rtl/cvac_top.sv */
// acquisition unit control: registers, conversion sequencer and front end decode
`include "cvac_map.svh"
module cvac_top
(
  input wire logic core_clk, // cpu clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [7:0] port_addr, // peripheral port address
  input wire logic [7:0] port_wdata, // peripheral port write data
  input wire logic port_wr, // write strobe
  input wire logic port_rd, // read strobe
  output logic [7:0] port_rdata, // read data, registered
  input wire logic tick_32k, // one-cycle pulse per timebase period
  input wire logic pos_conv_up_pulse, // positive converter up pulse
  input wire logic pos_conv_down_pulse, // positive converter down pulse
  input wire logic neg_conv_up_pulse, // negative converter up pulse
  input wire logic neg_conv_down_pulse, // negative converter down pulse
  output logic conv_power_on, // converter analog power
  output logic bias_cancel_circuit, // bias cancellation enable
  output logic [2:0] bias_cancel_pins, // cell1..cell3 tops cancelled
  output logic [3:0] fe_pos_node, // positive mux node
  output logic [3:0] fe_neg_node, // negative mux node
  output logic fe_high_range, // 20.48 V range selected
  output logic fe_sel_valid, // channel code is defined for mode
  output logic [1:0] conv_resolution, // resolution code to analog
  output logic chop_enable, // offset cancellation
  output logic conv_begin_irq, // one-cycle begin interrupt
  output logic conv_end_irq // one-cycle end interrupt
);
  //----------------------------------------
  // registers
  //----------------------------------------
  logic [7:0] fe_cfg_q;
  logic [7:0] ctl_q;
  logic [15:0] result_q;
  logic go_wr;
  logic done_ev;
  logic start_ev;

  assign go_wr = port_wr && (port_addr == `CVAC_ADDR_CONV_CTL)
    && port_wdata[`CVAC_GO_BIT];

  // all access rides the peripheral port [R3]
  always_ff @(posedge core_clk)
  begin
    if (rst)
      fe_cfg_q <= `CVAC_FE_CFG_RST;
    else if (port_wr && port_addr == `CVAC_ADDR_FE_CFG)
      fe_cfg_q <= port_wdata;
  end

  // go is set by write and cleared by completion; running ignores new go writes but still takes bits 5:1
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ctl_q <= `CVAC_CONV_CTL_RST;
    else
    begin
      if (port_wr && port_addr == `CVAC_ADDR_CONV_CTL)
      begin
        ctl_q[7:1] <= {2'b00, port_wdata[5:1]}; // [R18] [R20]
        if (!ctl_q[`CVAC_GO_BIT])
          ctl_q[`CVAC_GO_BIT] <= port_wdata[`CVAC_GO_BIT]; // [R12] [R19] [R22]
      end
      if (done_ev)
        ctl_q[`CVAC_GO_BIT] <= 1'b0; // [R13]
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      port_rdata <= 8'h00;
    else if (port_rd)
    begin
      case (port_addr)
        `CVAC_ADDR_FE_CFG: port_rdata <= fe_cfg_q;
        `CVAC_ADDR_CONV_CTL: port_rdata <= ctl_q;
        `CVAC_ADDR_RES_LO: port_rdata <= result_q[7:0]; // [R14] [R21]
        `CVAC_ADDR_RES_HI: port_rdata <= result_q[15:8]; // [R14] [R21]
        default: port_rdata <= 8'h00;
      endcase
    end
  end

  //----------------------------------------
  // sequencer on the timebase ticks
  //----------------------------------------
  typedef enum {ST_IDLE, ST_WAKE, ST_CONV, ST_DONE} cvac_state_e;
  cvac_state_e state_q;
  logic [3:0] wake_q;
  logic [16:0] period_q;
  logic [16:0] period_len;
  logic begin_tgl_q;
  logic end_tgl_q;
  logic begin_p;
  logic end_p;

  // 2^n timebase ticks per conversion for n result bits [R1] [R18]
  function automatic logic [16:0] res_len(input logic [1:0] code);
    case (code)
      2'b00: res_len = 17'h00800;
      2'b01: res_len = 17'h02000;
      2'b10: res_len = 17'h08000;
      default: res_len = 17'h10000;
    endcase
  endfunction

  assign period_len = res_len(ctl_q[2:1]);
  assign start_ev = (state_q == ST_IDLE) && ctl_q[`CVAC_GO_BIT] && !done_ev;
  assign done_ev = (state_q == ST_DONE);

  // runs on ticks alone, no cpu involvement [R17]
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      wake_q <= 4'h0;
      period_q <= 17'h00000;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start_ev)
          begin
            state_q <= ST_WAKE;
            wake_q <= 4'h0;
          end
        end
        ST_WAKE:
        begin
          if (tick_32k)
          begin
            wake_q <= wake_q + 4'h1;
            if (wake_q == `CVAC_WAKE_TICKS - 4'h1)
            begin
              state_q <= ST_CONV;
              period_q <= 17'h00000;
            end
          end
        end
        ST_CONV:
        begin
          if (tick_32k)
          begin
            period_q <= period_q + 17'h00001;
            if (period_q == period_len - 17'h00001)
              state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // power drops with no software action once done [R2]
  assign conv_power_on = (state_q != ST_IDLE) && (state_q != ST_DONE);

  //----------------------------------------
  // counters and result
  //----------------------------------------
  cvac_pkg::cvac_count_t pos_cnt;
  cvac_pkg::cvac_count_t neg_cnt;
  cvac_pkg::cvac_count_t diff;
  logic counting;

  assign counting = (state_q == ST_CONV);

  cvac_updown u_pos
  (
    .core_clk(core_clk),
    .rst(rst),
    .clear(start_ev),
    .enable(counting),
    .up(pos_conv_up_pulse),
    .down(pos_conv_down_pulse),
    .count(pos_cnt)
  );

  cvac_updown u_neg
  (
    .core_clk(core_clk),
    .rst(rst),
    .clear(start_ev),
    .enable(counting),
    .up(neg_conv_up_pulse),
    .down(neg_conv_down_pulse),
    .count(neg_cnt)
  );

  assign diff = pos_cnt - neg_cnt;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      result_q <= 16'h0000;
    else if (done_ev)
      result_q <= diff[15:0]; // [R14]
  end

  //----------------------------------------
  // interrupts, toggled in the sequencer and resynchronised
  //----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      begin_tgl_q <= 1'b0;
      end_tgl_q <= 1'b0;
    end
    else
    begin
      if (start_ev && ctl_q[`CVAC_IRQ_EN_BIT])
        begin_tgl_q <= ~begin_tgl_q; // [R15]
      if (done_ev && ctl_q[`CVAC_IRQ_EN_BIT])
        end_tgl_q <= ~end_tgl_q; // [R15]
    end
  end

  cvac_pulse_sync u_bsync
  (
    .core_clk(core_clk),
    .rst(rst),
    .level_in(begin_tgl_q),
    .pulse_out(begin_p)
  );

  cvac_pulse_sync u_esync
  (
    .core_clk(core_clk),
    .rst(rst),
    .level_in(end_tgl_q),
    .pulse_out(end_p)
  );

  assign conv_begin_irq = begin_p; // [R23]
  assign conv_end_irq = end_p; // [R23]

  //----------------------------------------
  // front end decode
  //----------------------------------------
  logic [1:0] cells;
  logic [1:0] mode;
  logic [2:0] sel;

  assign cells = fe_cfg_q[`CVAC_CELL_LSB +: 2];
  assign mode = fe_cfg_q[`CVAC_MODE_LSB +: 2];
  assign sel = fe_cfg_q[`CVAC_SEL_LSB +: 3];

  // bias cancel only while the converter is working [R4] [R5]
  always_comb
  begin
    bias_cancel_circuit = (cells != 2'b00) && counting;
    case (cells)
      2'b01: bias_cancel_pins = counting ? 3'b001 : 3'b000;
      2'b10: bias_cancel_pins = counting ? 3'b011 : 3'b000;
      2'b11: bias_cancel_pins = counting ? 3'b111 : 3'b000;
      default: bias_cancel_pins = 3'b000;
    endcase
  end

  function automatic logic [3:0] cell_node(input logic [1:0] idx);
    cell_node = 4'(cvac_pkg::CVAC_N_C1) + {2'b00, idx};
  endfunction

  // [R6] [R7] [R8] [R9] [R10]
  always_comb
  begin
    fe_pos_node = 4'(cvac_pkg::CVAC_N_NONE);
    fe_neg_node = 4'(cvac_pkg::CVAC_N_GND);
    fe_high_range = (mode != 2'b00);
    fe_sel_valid = 1'b0;
    case (mode)
      2'b00:
      begin
        fe_sel_valid = (sel[2:1] != 2'b11);
        if (fe_sel_valid)
          fe_pos_node = {1'b0, sel};
      end
      2'b01:
      begin
        fe_neg_node = 4'(cvac_pkg::CVAC_N_PACK);
        fe_sel_valid = !sel[2];
        if (fe_sel_valid)
          fe_pos_node = cell_node(sel[1:0]);
      end
      2'b10:
      begin
        fe_sel_valid = !sel[2];
        if (fe_sel_valid)
          fe_pos_node = cell_node(sel[1:0]);
      end
      default:
      begin
        fe_sel_valid = !sel[2];
        if (fe_sel_valid)
        begin
          fe_pos_node = cell_node(sel[1:0]);
          fe_neg_node = (sel[1:0] == 2'b00) ? 4'(cvac_pkg::CVAC_N_PACK)
            : cell_node(sel[1:0] - 2'b01);
        end
      end
    endcase
  end

  assign conv_resolution = ctl_q[2:1];
  assign chop_enable = ctl_q[`CVAC_CHOP_BIT];

  //----------------------------------------
  // checks
  //----------------------------------------
  sequence go_taken_s;
    go_wr && !ctl_q[0] && state_q == ST_IDLE;
  endsequence

  go_start_a: assert property (@(posedge core_clk) disable iff (rst)
    go_taken_s |=> ctl_q[0] ##1 conv_power_on) else $error("go did not start"); // [R12]
  go_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    done_ev |=> !ctl_q[0]) else $error("go not cleared"); // [R13]
  power_down_a: assert property (@(posedge core_clk) disable iff (rst)
    done_ev |-> !conv_power_on ##1 !conv_power_on) else $error("power stayed on"); // [R2]
  rerun_ignored_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ST_CONV && go_wr) |=> state_q != ST_WAKE) else $error("restarted"); // [R22]
  bias_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    !counting |-> !bias_cancel_circuit) else $error("bias on while idle"); // [R5]
  irq_begin_a: assert property (@(posedge core_clk) disable iff (rst)
    (start_ev && ctl_q[3]) |-> ##3 conv_begin_irq) else $error("no begin irq"); // [R15]
  irq_off_a: assert property (@(posedge core_clk) disable iff (rst)
    (done_ev && !ctl_q[3]) |-> ##3 !conv_end_irq) else $error("spurious end irq"); // [R15]
  irq_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
    conv_end_irq |=> !conv_end_irq) else $error("end irq too long"); // [R23]
  result_load_a: assert property (@(posedge core_clk) disable iff (rst)
    done_ev |=> result_q == $past(diff[15:0])) else $error("result not loaded"); // [R14]
  diff_node_a: assert property (@(posedge core_clk) disable iff (rst)
    (mode == 2'b11 && sel == 3'b000) |-> fe_neg_node == 4'h4) else $error("diff ref"); // [R10]
endmodule

/* File: rtl/cvac_updown.sv */
// up/down pulse counter for one voltage-to-frequency converter
module cvac_updown
(
  input wire logic core_clk, // cpu clock
  input wire logic rst, // synchronous reset
  input wire logic clear, // zero the count at conversion start
  input wire logic enable, // count only while converting
  input wire logic up, // one pulse per positive lsb step
  input wire logic down, // one pulse per negative lsb step
  output cvac_pkg::cvac_count_t count // running signed count
);
  always_ff @(posedge core_clk)
  begin
    if (rst || clear)
      count <= '0;
    else if (enable && (up ^ down))
      count <= up ? count + 18'h00001 : count - 18'h00001; // [R16]
  end
endmodule

/* File: tb/cvac_cpu_model.sv */
// cpu-side peripheral port model for the acquisition control
module cvac_cpu_model
(
  input wire logic core_clk, // cpu clock
  output logic [7:0] port_addr, // address
  output logic [7:0] port_wdata, // write data
  output logic port_wr, // write strobe
  output logic port_rd, // read strobe
  input wire logic [7:0] port_rdata // registered read data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // port cycles
  // ----------------------------------------
  initial
  begin
    port_addr = 8'h00;
    port_wdata = 8'h00;
    port_wr = 1'b0;
    port_rd = 1'b0;
  end
  // all register traffic goes through this port
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    port_addr <= a;
    port_wdata <= d;
    port_wr <= 1'b1;
    @(posedge core_clk);
    port_wr <= 1'b0;
    // released lines show the inverse so a stale value is never trusted
    port_addr <= ~a;
    port_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    port_addr <= a;
    port_rd <= 1'b1;
    @(posedge core_clk);
    port_rd <= 1'b0;
    port_addr <= ~a;
    @(posedge core_clk);
    #1;
    d = port_rdata;
  endtask
endmodule

/* File: tb/test_cell_voltage_acq_control.sv */
// self-checking bench for the acquisition control
module test_cell_voltage_acq_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, tick_32k, port_wr, port_rd;
  logic [7:0] port_addr, port_wdata, port_rdata, rv, lo;
  logic pos_up, pos_dn, neg_up, neg_dn;
  logic conv_power_on, bias_cancel_circuit, fe_high_range, fe_sel_valid;
  logic chop_enable, conv_begin_irq, conv_end_irq;
  logic [2:0] bias_cancel_pins;
  logic [3:0] fe_pos_node, fe_neg_node;
  logic [1:0] conv_resolution;
  int bad_count, num_checks, beg_n, end_n, pwr_n;
  cvac_top dut
  (
    .core_clk(core_clk), .rst(rst), .port_addr(port_addr), .port_wdata(port_wdata),
    .port_wr(port_wr), .port_rd(port_rd), .port_rdata(port_rdata), .tick_32k(tick_32k),
    .pos_conv_up_pulse(pos_up), .pos_conv_down_pulse(pos_dn),
    .neg_conv_up_pulse(neg_up), .neg_conv_down_pulse(neg_dn),
    .conv_power_on(conv_power_on), .bias_cancel_circuit(bias_cancel_circuit),
    .bias_cancel_pins(bias_cancel_pins), .fe_pos_node(fe_pos_node),
    .fe_neg_node(fe_neg_node), .fe_high_range(fe_high_range), .fe_sel_valid(fe_sel_valid),
    .conv_resolution(conv_resolution), .chop_enable(chop_enable),
    .conv_begin_irq(conv_begin_irq), .conv_end_irq(conv_end_irq)
  );
  cvac_cpu_model cpu
  (
    .core_clk(core_clk), .port_addr(port_addr), .port_wdata(port_wdata),
    .port_wr(port_wr), .port_rd(port_rd), .port_rdata(port_rdata)
  );
  // ----------------------------------------
  // clock, monitors and checking
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // pulse width and count both show in the high-cycle tally
  always @(posedge core_clk)
  begin
    if (conv_begin_irq === 1'b1) beg_n++;
    if (conv_end_irq === 1'b1) end_n++;
    if (conv_power_on === 1'b1) pwr_n++;
  end
  task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_n(input int g, input int e);
    num_checks++;
    if (g != e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    cpu.rd(8'h10, rv);
    chk_v(rv, 8'h00);
    cpu.rd(8'h11, rv);
    chk_v(rv, 8'h32);
    cpu.rd(8'h13, rv);
    chk_v(rv, 8'h00);
    cpu.rd(8'h20, rv);
    chk_v(rv, 8'h00);
    chk_v(conv_power_on, 1'b0);
    cpu.wr(8'h11, 8'h36);
    cpu.rd(8'h11, rv);
    chk_v(rv, 8'h36);
    chk_v(conv_resolution, 2'b11);
    cpu.wr(8'h11, 8'h26);
    #1;
    chk_v(chop_enable, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_modes();
    // config byte then expected positive and negative node; node 10 means undefined
    logic [15:0] tab [15] = '{16'h0000, 16'h2110, 16'h4550, 16'h06a0, 16'h6864,
      16'h0b94, 16'h0ca0, 16'h3060, 16'h14a0, 16'h7864, 16'h1a87, 16'h7b98,
      16'h0440, 16'h1170, 16'h1976};
    for (int i = 0; i < 15; i++)
    begin
      cpu.wr(8'h10, tab[i][15:8]);
      #1;
      chk_v(fe_pos_node, tab[i][7:4]);
      chk_v(fe_sel_valid, tab[i][7:4] != 4'ha);
      if (tab[i][7:4] != 4'ha)
        chk_v(fe_neg_node, tab[i][3:0]);
      chk_v(fe_high_range, tab[i][12:11] != 2'b00);
      chk_v(bias_cancel_circuit, 1'b0);
      cpu.rd(8'h10, rv);
      chk_v(rv, tab[i][15:8]);
    end
    $display("test modes done");
  endtask
  task automatic run_conv(input logic [7:0] cfg, input logic [7:0] ctl, input int np,
    input int nn, input int len);
    int k;
    cpu.wr(8'h10, cfg);
    beg_n = 0;
    end_n = 0;
    pwr_n = 0;
    cpu.wr(8'h11, ctl);
    for (k = 0; k < 20 && conv_power_on !== 1'b1; k++)
    begin
      @(posedge core_clk);
      #1;
    end
    chk_v(conv_power_on, 1'b1);
    repeat (10) @(posedge core_clk);
    chk_v(bias_cancel_circuit, cfg[6:5] != 2'b00);
    chk_v(bias_cancel_pins, 3'(3'b111 >> (2'd3 - cfg[6:5])));
    repeat (np)
    begin
      pos_up <= 1'b1;
      @(posedge core_clk);
      pos_up <= 1'b0;
      @(posedge core_clk);
    end
    repeat (nn)
    begin
      neg_up <= 1'b1;
      @(posedge core_clk);
      neg_up <= 1'b0;
      @(posedge core_clk);
    end
    // unequal down counts so a dead or inverted down input shows in the result
    repeat (2)
    begin
      neg_dn <= 1'b1;
      @(posedge core_clk);
      neg_dn <= 1'b0;
      @(posedge core_clk);
    end
    pos_dn <= 1'b1;
    @(posedge core_clk);
    pos_dn <= 1'b0;
    @(posedge core_clk);
    cpu.wr(8'h11, ctl);
    k = 0;
    do cpu.rd(8'h11, rv); while (rv[0] === 1'b1 && k++ < 20000);
    chk_v(rv, ctl & 8'h3e);
    repeat (5) @(posedge core_clk);
    chk_v(conv_power_on, 1'b0);
    chk_v(bias_cancel_circuit, 1'b0);
    chk_n(int'(pwr_n >= len && pwr_n <= len + 16), 1);
    chk_n(beg_n, int'(ctl[3]));
    chk_n(end_n, int'(ctl[3]));
    cpu.rd(8'h12, lo);
    cpu.rd(8'h13, rv);
    chk_v({rv, lo}, 16'(np - nn + 1));
  endtask
  task automatic t_conv_irq();
    run_conv(8'h7b, 8'h39, 5, 2, 2048);
    $display("test conversion with interrupts done");
  endtask
  task automatic t_conv_quiet();
    run_conv(8'h21, 8'h33, 7, 3, 8192);
    cpu.wr(8'h12, 8'hff);
    cpu.rd(8'h12, rv);
    chk_v(rv, 8'h05);
    $display("test quiet conversion done");
  endtask
  task automatic t_conv_long();
    run_conv(8'h42, 8'h3d, 3, 3, 32768);
    $display("test long conversion done");
  endtask
  initial
  begin
    rst = 1'b1;
    tick_32k = 1'b1;
    {pos_up, pos_dn, neg_up, neg_dn} = 4'h0;
    bad_count = 0;
    num_checks = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_modes();
    t_conv_irq();
    t_conv_quiet();
    t_conv_long();
    wrap_up();
  end
  initial
  begin
    #300us;
    bad_count++;
    wrap_up();
  end
endmodule
